// ===== src/csb_core_status.sv
// core status register, bank selection and program counter
`timescale 1ns/1ps

// Behaviour
// - program counter is thirteen bits wide, covering 8K instruction words.
// - fetch addresses above 0fffh wrap onto the implemented 4K words.
// - reset loads pc with 0000h; interrupt entry loads 0004h.
// - flag-updating writes discard written zero, nibble-carry and carry bits.
// - timeout and power-down flags ignore all instruction writes.
// - status appears at offset 03h in all four banks.
// - indirect bank bit forms top bit of the indirect address.
// - two direct bank bits select one of four 128-byte banks.
// - timeout and power-down flags follow power-up, kick, sleep, timeout.
// - zero on zero result; nibble carry and carry out of nibble, msb.
// - on subtraction carry and digit carry are inverted borrows.
// - power-on clears bank bits and sets timeout and power-down flags.
// - writes without flag update land on all writable bits unchanged.
module csb_core_status (
    input wire logic clk_sys_in,                 // core clock, 40 MHz
    input wire logic rst_b_in,                   // power-on reset, low
    input wire logic pc_load_in,                 // load pc from pc_target_in
    input wire logic [12:0] pc_target_in,        // jump target
    input wire logic pc_inc_in,                  // advance pc by one
    input wire logic intr_entry_in,              // interrupt entry
    input wire csb_pkg::csb_alu_req_t alu_in,    // flag update request
    input wire csb_pkg::csb_wr_req_t wr_in,      // register write
    input wire csb_pkg::csb_evt_t evt_in,        // reset-status events
    input wire logic [6:0] dir_ofs_in,           // direct operand address
    input wire logic [7:0] ind_ptr_in,           // indirect pointer value
    output logic [12:0] pc_out,                  // program counter
    output logic [11:0] fetch_addr_out,          // implemented fetch address
    output logic [7:0] flags_out,                // status register value
    output logic [8:0] dir_addr_out,             // direct data address
    output logic [8:0] ind_addr_out              // indirect data address
);
    import csb_pkg::*;

    // =========================================================
    // program counter
    logic [12:0] pc_ff;
    logic [12:0] nxt_pc;

    always_comb begin
        nxt_pc = pc_ff;
        if (intr_entry_in) begin
            nxt_pc = CSB_INTR_VEC;
        end else if (pc_load_in) begin
            nxt_pc = pc_target_in;
        end else if (pc_inc_in) begin
            nxt_pc = pc_ff + 13'h0001;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pc_ff <= CSB_RESET_VEC;
        end else begin
            pc_ff <= nxt_pc;
        end
    end

    assign pc_out = pc_ff;
    // upper half aliases the implemented memory
    assign fetch_addr_out = pc_ff[CSB_IMPL_W-1:0];

    // =========================================================
    // flag logic
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] res;
    logic res_z;
    logic res_nib;
    logic res_c;

    always_comb begin
        sum9 = 9'h000;
        sum5 = 5'h00;
        case (alu_in.kind)
            2'h1: begin
                // carries out of nibble and msb
                sum9 = {1'b0, alu_in.a} + {1'b0, alu_in.b};
                sum5 = {1'b0, alu_in.a[3:0]} + {1'b0, alu_in.b[3:0]};
            end
            2'h2: begin
                // two's complement add gives inverted borrow
                sum9 = {1'b0, alu_in.a} + {1'b0, ~alu_in.b} + 9'h001;
                sum5 = {1'b0, alu_in.a[3:0]} + {1'b0, ~alu_in.b[3:0]}
                    + 5'h01;
            end
            2'h3: begin
                sum9 = {1'b0, alu_in.a};
            end
            default: begin
                sum9 = 9'h000;
            end
        endcase
        res = sum9[7:0];
        res_z = (res == 8'h00);
        res_nib = sum5[4];
        res_c = sum9[8];
    end

    logic upd_any;
    logic upd_carry;
    assign upd_any = (alu_in.kind != 2'h0);
    // logic operations update z only; carries stay put
    assign upd_carry = (alu_in.kind == 2'h1) || (alu_in.kind == 2'h2);

    // =========================================================
    // status register
    logic [7:0] flags_ff;
    logic [7:0] nxt_flags;
    logic wr_hit;

    // any bank reaches the single register
    assign wr_hit = wr_in.en && (wr_in.addr[6:0] == CSB_FLAGS_OFS);

    always_comb begin
        nxt_flags = flags_ff;
        if (wr_hit) begin
            // plain write lands on writable bits
            nxt_flags[CSB_IND_BANK_BIT] = wr_in.data[CSB_IND_BANK_BIT];
            nxt_flags[CSB_DIR_HI_BIT] = wr_in.data[CSB_DIR_HI_BIT];
            nxt_flags[CSB_DIR_LO_BIT] = wr_in.data[CSB_DIR_LO_BIT];
            nxt_flags[CSB_Z_BIT] = wr_in.data[CSB_Z_BIT];
            nxt_flags[CSB_NIB_BIT] = wr_in.data[CSB_NIB_BIT];
            nxt_flags[CSB_C_BIT] = wr_in.data[CSB_C_BIT];
        end
        // flag result overrides the written value
        // both land on the same edge
        if (upd_any) begin
            // all three written flags drop, even where only zero is computed
            nxt_flags[CSB_NIB_BIT] = flags_ff[CSB_NIB_BIT];
            nxt_flags[CSB_C_BIT] = flags_ff[CSB_C_BIT];
            nxt_flags[CSB_Z_BIT] = res_z;
            if (upd_carry) begin
                nxt_flags[CSB_NIB_BIT] = res_nib;
                nxt_flags[CSB_C_BIT] = res_c;
            end
        end
        // reset-status events; timeout has priority over kick
        if (evt_in.wdt_kick) begin
            nxt_flags[CSB_EXPIRY_BIT] = 1'b1;
            nxt_flags[CSB_SLEEP_BIT] = 1'b1;
        end else if (evt_in.sleep) begin
            nxt_flags[CSB_EXPIRY_BIT] = 1'b1;
            nxt_flags[CSB_SLEEP_BIT] = 1'b0;
        end
        if (evt_in.wdt_timeout) begin
            nxt_flags[CSB_EXPIRY_BIT] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flags_ff <= {CSB_BANK_RST, CSB_EXPIRY_RST, CSB_SLEEP_RST,
                CSB_ARITH_RST};
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign flags_out = flags_ff;

    // =========================================================
    // data address formation
    // direct bank above seven-bit operand
    assign dir_addr_out = {flags_ff[CSB_DIR_HI_BIT], flags_ff[CSB_DIR_LO_BIT],
        dir_ofs_in};
    // indirect bank bit on top of the pointer
    assign ind_addr_out = {flags_ff[CSB_IND_BANK_BIT], ind_ptr_in};

    // =========================================================
    // checks
    sequence intr_seq;
        intr_entry_in;
    endsequence

    property intr_vec_p;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        intr_seq |=> (pc_out == CSB_INTR_VEC);
    endproperty

    intr_vector_a: assert property (intr_vec_p)
        else $error("interrupt entry did not load vector 0004h");

    pc_wrap_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        fetch_addr_out == pc_out[11:0])
        else $error("fetch address does not alias pc");

    pc_inc_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (pc_inc_in && !pc_load_in && !intr_entry_in)
        |=> pc_out == 13'($past(pc_out) + 13'h0001))
        else $error("pc did not advance by one");

    expiry_hold_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (!evt_in.wdt_kick && !evt_in.sleep && !evt_in.wdt_timeout)
        |=> $stable(flags_out[4:3]))
        else $error("timeout or power-down changed without an event");

    sleep_flags_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (evt_in.sleep && !evt_in.wdt_kick && !evt_in.wdt_timeout)
        |=> flags_out[4:3] == 2'b10)
        else $error("sleep did not leave flags at 10");

    wdt_expiry_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        evt_in.wdt_timeout |=> !flags_out[4])
        else $error("watchdog timeout did not clear timeout flag");

    zero_flag_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (alu_in.kind == 2'h1)
        |=> flags_out[2] == (8'($past(alu_in.a) + $past(alu_in.b)) == 8'h00))
        else $error("zero flag wrong after add");

    sub_borrow_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (alu_in.kind == 2'h2)
        |=> flags_out[0] == ($past(alu_in.a) >= $past(alu_in.b)))
        else $error("carry is not inverted borrow on sub");

    flag_win_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (wr_hit && alu_in.kind == 2'h1)
        |=> flags_out[2:0] == {
            8'($past(alu_in.a) + $past(alu_in.b)) == 8'h00,
            5'($past(alu_in.a[3:0])) + 5'($past(alu_in.b[3:0])) > 5'h0f,
            9'($past(alu_in.a)) + 9'($past(alu_in.b)) > 9'h0ff})
        else $error("written flags not discarded");

    plain_wr_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (wr_hit && !upd_any)
        |=> {flags_out[7:5], flags_out[2:0]}
            == {$past(wr_in.data[7:5]), $past(wr_in.data[2:0])})
        else $error("plain write did not land");

    same_cycle_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (wr_hit && upd_any)
        |=> flags_out[7:5] == $past(wr_in.data[7:5]))
        else $error("bank bits lost on flag-updating write");

    dir_addr_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        dir_addr_out[8:7] == flags_out[6:5]
        && dir_addr_out[6:0] == dir_ofs_in)
        else $error("direct address not formed from bank bits");

    ind_addr_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        ind_addr_out[8] == flags_out[7])
        else $error("indirect bank bit not on top");

    // logic kind yields only zero; carries keep their value, not the write
    logic_keep_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (wr_hit && alu_in.kind == 2'h3)
        |=> flags_out[1:0] == $past(flags_out[1:0]))
        else $error("written carries landed on a logic operation");

    logic_zero_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (alu_in.kind == 2'h3)
        |=> flags_out[2] == ($past(alu_in.a) == 8'h00))
        else $error("zero flag wrong after logic operation");

    add_carry_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (alu_in.kind == 2'h1)
        |=> flags_out[1:0] == {
            5'($past(alu_in.a[3:0])) + 5'($past(alu_in.b[3:0])) > 5'h0f,
            9'($past(alu_in.a)) + 9'($past(alu_in.b)) > 9'h0ff})
        else $error("carry flags wrong after add");

    sub_nibble_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (alu_in.kind == 2'h2)
        |=> flags_out[1] == ($past(alu_in.a[3:0]) >= $past(alu_in.b[3:0])))
        else $error("digit carry is not inverted borrow on sub");

    sequence kick_seq;
        evt_in.wdt_kick && !evt_in.wdt_timeout;
    endsequence

    kick_flags_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        kick_seq |=> flags_out[4:3] == 2'h3)
        else $error("watchdog kick did not set both flags");

    bank_hold_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        !wr_hit |=> $stable(flags_out[7:5]))
        else $error("bank bits changed without a write");

    pc_load_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (pc_load_in && !intr_entry_in) |=> pc_out == $past(pc_target_in))
        else $error("pc did not take the jump target");
endmodule : csb_core_status

// ===== src/csb_pkg.sv
// package: constants and carrier types for the core status and bank-select block
package csb_pkg;
    // =========================================================
    // program counter space
    localparam int CSB_PC_W = 13;
    localparam int CSB_IMPL_W = 12;
    localparam logic [12:0] CSB_RESET_VEC = 13'h0000;
    localparam logic [12:0] CSB_INTR_VEC = 13'h0004;
    localparam logic [12:0] CSB_IMPL_TOP = 13'h0fff;
    // =========================================================
    // data memory and register placement
    localparam int CSB_DADDR_W = 9;
    localparam logic [6:0] CSB_FLAGS_OFS = 7'h03;
    // =========================================================
    // field positions of core_flags_bank_select
    localparam int CSB_IND_BANK_BIT = 7;
    localparam int CSB_DIR_HI_BIT = 6;
    localparam int CSB_DIR_LO_BIT = 5;
    localparam int CSB_EXPIRY_BIT = 4;
    localparam int CSB_SLEEP_BIT = 3;
    localparam int CSB_Z_BIT = 2;
    localparam int CSB_NIB_BIT = 1;
    localparam int CSB_C_BIT = 0;
    // =========================================================
    // reset values; arithmetic flags are undefined, held at zero here
    localparam logic [2:0] CSB_BANK_RST = 3'h0;
    localparam logic CSB_EXPIRY_RST = 1'b1;
    localparam logic CSB_SLEEP_RST = 1'b1;
    localparam logic [2:0] CSB_ARITH_RST = 3'h0;

    typedef enum {
        CSB_OP_NONE,
        CSB_OP_ADD,
        CSB_OP_SUB,
        CSB_OP_LOGIC
    } csb_alu_op_t;

    // flag-update request from the execution datapath
    typedef struct packed {
        logic [1:0] kind;      // 0 none, 1 add, 2 sub, 3 logic (z only)
        logic [7:0] a;         // first operand (minuend on sub)
        logic [7:0] b;         // second operand (subtrahend on sub)
    } csb_alu_req_t;

    // data-memory write from the execution datapath
    typedef struct packed {
        logic en;
        logic [8:0] addr;      // full bank-qualified address
        logic [7:0] data;
    } csb_wr_req_t;

    // sleep, watchdog and reset events
    typedef struct packed {
        logic wdt_kick;        // watchdog_kick_instruction executed
        logic sleep;           // sleep instruction executed
        logic wdt_timeout;     // watchdog expired
    } csb_evt_t;
endpackage : csb_pkg

// ===== tb/csb_dp_model.sv
// execution datapath model that issues core requests
`timescale 1ns/1ps
module csb_dp_model (
    input wire logic clk_sys_in, // core clock
    output csb_pkg::csb_alu_req_t alu_out, // flag update
    output csb_pkg::csb_wr_req_t wr_out, // register write
    output csb_pkg::csb_evt_t evt_out, // status events
    output logic [2:0] pc_ctl_out, // load, inc, interrupt
    output logic [12:0] tgt_out // jump target
);
    import csb_pkg::*;
    initial begin
        alu_out = '0;
        wr_out = '0;
        evt_out = '0;
        pc_ctl_out = 3'h0;
        tgt_out = 13'h0000;
    end
    // ====================
    // one request a cycle
    // held over the sampling edge until the next call replaces it,
    // so event pulses last exactly one cycle when calls follow on
    task automatic issue(input csb_alu_req_t a, input csb_wr_req_t w,
            input csb_evt_t e, input logic [2:0] c, input logic [12:0] t);
        @(negedge clk_sys_in);
        alu_out = a;
        wr_out = w;
        evt_out = e;
        pc_ctl_out = c;
        tgt_out = t;
        @(posedge clk_sys_in);
    endtask : issue
endmodule : csb_dp_model

// ===== tb/tb_core_status_bank_select.sv
// testbench for the core status and bank-select block
`timescale 1ns/1ps
module tb_core_status_bank_select;
    import csb_pkg::*;
    logic clk_sys_in;
    logic rst_b_in;
    logic [6:0] dir_ofs_in;
    logic [7:0] ind_ptr_in;
    csb_alu_req_t alu;
    csb_wr_req_t wr;
    csb_evt_t evt;
    logic [2:0] pc_ctl;
    logic [12:0] tgt;
    logic [12:0] pc;
    logic [11:0] fetch;
    logic [7:0] fl;
    logic [8:0] dir_a;
    logic [8:0] ind_a;
    logic exp_wdt;
    logic exp_slp;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    csb_core_status i_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .pc_load_in(pc_ctl[2]), .pc_target_in(tgt), .pc_inc_in(pc_ctl[1]),
        .intr_entry_in(pc_ctl[0]), .alu_in(alu), .wr_in(wr), .evt_in(evt),
        .dir_ofs_in(dir_ofs_in), .ind_ptr_in(ind_ptr_in), .pc_out(pc),
        .fetch_addr_out(fetch), .flags_out(fl), .dir_addr_out(dir_a),
        .ind_addr_out(ind_a));
    csb_dp_model i_dp (.clk_sys_in(clk_sys_in), .alu_out(alu), .wr_out(wr),
        .evt_out(evt), .pc_ctl_out(pc_ctl), .tgt_out(tgt));
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    // ====================
    // shared tasks
    task automatic chk(input string what, input logic [12:0] exp,
            input logic [12:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic run(input logic [17:0] a, input logic [17:0] w,
            input logic [2:0] e, input logic [2:0] c, input logic [12:0] t);
        i_dp.issue(a, w, e, c, t);
        #1;
    endtask : run
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    // ====================
    // scenarios
    task automatic t_reset();
        run(18'h0, 18'h0, 3'h0, 3'h0, 13'h0);
        @(negedge clk_sys_in);
        rst_b_in = 1'b0;
        repeat (10) @(negedge clk_sys_in);
        chk("flags", 13'h0018, 13'(fl));
        chk("pc", 13'h0000, pc);
        rst_b_in = 1'b1;
        exp_wdt = 1'b1;
        exp_slp = 1'b1;
        run(18'h0, 18'h0, 3'h0, 3'h2, 13'h0);
        chk("pc", 13'h0001, pc);
        chk("flags", 13'h0018, 13'(fl));
        $display("test reset done");
    endtask : t_reset
    task automatic t_bank();
        logic [7:0] d;
        logic [7:0] x;
        for (int i = 0; i < 4; i++) begin
            d = {i[0], i[1], i[0], 2'b00, 3'(i + 3)};
            x = {d[7:5], exp_wdt, exp_slp, d[2:0]};
            run(18'h0, {1'b1, 2'(i), 7'h03, d}, 3'h0, 3'h0, 13'h0);
            chk("flags", 13'(x), 13'(fl));
            @(negedge clk_sys_in);
            dir_ofs_in = 7'h40 + 7'(i);
            ind_ptr_in = 8'ha5 ^ 8'(i);
            #1;
            chk("dir", 13'({d[6:5], dir_ofs_in}), 13'(dir_a));
            chk("ind", 13'({d[7], ind_ptr_in}), 13'(ind_a));
        end
        run(18'h0, {1'b1, 9'h004, 8'hff}, 3'h0, 3'h0, 13'h0);
        chk("other", 13'(x), 13'(fl));
        $display("test bank done");
    endtask : t_bank
    task automatic t_alu();
        logic [1:0] k [7] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3};
        logic [7:0] a [7] = '{8'hff, 8'h08, 8'h10, 8'h05, 8'h00, 8'h00, 8'h05};
        logic [7:0] b [7] = '{8'h01, 8'h08, 8'h01, 8'h05, 8'h01, 8'h00, 8'h00};
        logic [7:0] w;
        logic [8:0] s;
        logic [4:0] n;
        logic [7:0] e;
        logic [1:0] keep;
        e = 8'h00;
        for (int i = 0; i < 7; i++) begin
            keep = e[1:0];
            w = {3'(i), 5'h07};
            if (k[i] == 2'h2) begin
                s = {1'b0, a[i]} - {1'b0, b[i]};
                n = {1'b0, a[i][3:0]} - {1'b0, b[i][3:0]};
                s[8] = ~s[8];
                n[4] = ~n[4];
            end else begin
                s = {1'b0, a[i]} + {1'b0, b[i]};
                n = {1'b0, a[i][3:0]} + {1'b0, b[i][3:0]};
            end
            e = {w[7:5], exp_wdt, exp_slp, s[7:0] == 8'h00, n[4], s[8]};
            if (k[i] == 2'h3) begin
                // carries keep the last result; the written bits are dropped
                e[2:0] = {a[i] == 8'h00, keep};
            end
            run({k[i], a[i], b[i]}, {1'b1, 2'(i), 7'h03, w}, 3'h0, 3'h0,
                13'h0);
            chk("alu", 13'(e), 13'(fl));
        end
        $display("test alu done");
    endtask : t_alu
    task automatic t_evt();
        logic [2:0] ev [6] = '{3'h2, 3'h1, 3'h4, 3'h1, 3'h2, 3'h5};
        for (int i = 0; i < 6; i++) begin
            run(18'h0, 18'h0, ev[i], 3'h0, 13'h0);
            exp_wdt = ev[i][0] ? 1'b0 : ((|ev[i][2:1]) ? 1'b1 : exp_wdt);
            exp_slp = ev[i][2] ? 1'b1 : (ev[i][1] ? 1'b0 : exp_slp);
            chk("status", 13'({exp_wdt, exp_slp}), 13'(fl[4:3]));
        end
        run(18'h0, {1'b1, 9'h183, 8'h10}, 3'h0, 3'h0, 13'h0);
        chk("ro", 13'({3'h0, exp_wdt, exp_slp, 3'h0}), 13'(fl));
        $display("test events done");
    endtask : t_evt
    task automatic t_pc();
        logic [2:0] c [6] = '{3'h4, 3'h2, 3'h2, 3'h4, 3'h7, 3'h6};
        logic [12:0] t [6] = '{13'h1ffe, 13'h0, 13'h0, 13'h1005, 13'h0123,
            13'h0100};
        logic [12:0] x [6] = '{13'h1ffe, 13'h1fff, 13'h0000, 13'h1005,
            13'h0004, 13'h0100};
        for (int i = 0; i < 6; i++) begin
            run(18'h0, 18'h0, 3'h0, c[i], t[i]);
            chk("pc", x[i], pc);
            chk("fetch", 13'(x[i][11:0]), 13'(fetch));
        end
        $display("test pc done");
    endtask : t_pc
    // ====================
    // main sequence and hang guard
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        rst_b_in = 1'b0;
        dir_ofs_in = 7'h00;
        ind_ptr_in = 8'h00;
        t_reset();
        t_bank();
        t_alu();
        t_evt();
        t_pc();
        t_reset();
        test_done();
    end
endmodule : tb_core_status_bank_select
